/* File: core/ots_map.vh */
`ifndef OTS_MAP_VH
`define OTS_MAP_VH
// register indices, byte address is four times index
`define OTS_IDX_TUNE     8'hac
`define OTS_IDX_REQ      8'had
`define OTS_IDX_CUR      8'hae
`define OTS_IDX_SWCTL    8'haf
`define OTS_IDX_TRIM     8'hb0
`define OTS_IDX_FRQ      8'hb1
`define OTS_IDX_STAT     8'hb2
`define OTS_IDX_EVENT    8'hb4
// field positions
`define OTS_B_TEN        7
`define OTS_B_HOLD       6
`define OTS_B_LOCK       3
`define OTS_B_OOR        1
`define OTS_B_SWHOLD     7
`define OTS_B_XPWR       6
`define OTS_B_DONE       4
`define OTS_B_NRDY       3
`define OTS_B_EVFLAG     0
`define OTS_B_EVIE       1
// trim encoding
`define OTS_TRIM_MAX     6'h1f
`define OTS_TRIM_MIN     6'h20
`define OTS_TRIM_RST     6'h00
`define OTS_FRQ_LAST     4'h8
`define OTS_CTL_RST      8'h00
`endif

/* File: core/ots_osc_tune_switch.v */
`timescale 1ns/1ps
`default_nettype none
`include "ots_map.vh"
module ots_osc_tune_switch #(
  parameter        MEAS_PERIODS = 4,     // crystal periods per tuner cycle
  parameter [15:0] EXPECT_COUNT = 16'd2000, // nominal ticks per window
  parameter [7:0]  SRC_RESERVED = 8'h80, // one bit per reserved source
  parameter [3:0]  FRQ_RESET    = 4'h0   // frequency select after reset
) (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        crystalClk,        // crystal time base level
  input  wire        fastOscTick,       // one pulse per fast osc count
  input  wire        switchPermit,      // configuration setting
  input  wire [2:0]  resetClockChoice,  // strap, source at reset
  input  wire [3:0]  resetDividerChoice,// strap, divider at reset
  input  wire [7:0]  sourceReady,       // ready per source code
  input  wire [7:0]  oscEnabled,        // enable per status bit
  input  wire [7:0]  oscReady,          // ready per status bit
  input  wire        pllInputReady,
  input  wire        pllLocked,
  output reg  [5:0]  trimValue,
  output reg  [3:0]  freqSelect,
  output reg  [2:0]  activeSource,
  output reg  [3:0]  activeDivider,
  output reg         crystalHighPower,
  output reg         tunerIrq
);

  ////////////////////////////////////////////////////////////////////
  // window limits

  localparam [15:0] TOL    = EXPECT_COUNT / 16'd100; // 1% of nominal
  localparam [15:0] LIM_HI = EXPECT_COUNT + TOL;
  localparam [15:0] LIM_LO = EXPECT_COUNT - TOL;
  // period count is eight bits; cut the last edge index on purpose
  localparam [31:0] PER_FULL = MEAS_PERIODS - 1;
  localparam [7:0]  PER_LAST = PER_FULL[7:0];

  ////////////////////////////////////////////////////////////////////
  // state

  reg        tunerEnable;      // hardware owns trim
  reg        tuneHold;         // update hold bit
  reg        tuneLocked;       // within window
  reg        tuneOor;          // trim range exhausted
  reg        tunerEventFlag;   // sticky change event
  reg        tunerEventIe;     // irq enable
  reg [2:0]  reqSource;        // requested source
  reg [3:0]  reqDivider;       // requested divider
  reg        switchHold;       // hold switch when ready
  reg        newSrcReady;      // pending and ready
  reg        strapsTaken;      // straps loaded after release
  reg        xtalMeta;         // first sync stage
  reg        xtalSync;         // second sync stage
  reg        xtalLast;         // edge detector history
  reg [7:0]  periodCount;      // crystal edges in window
  reg [15:0] fastCount;        // fast ticks in window
  reg [7:0]  oscStatus;        // registered ready flags

  ////////////////////////////////////////////////////////////////////
  // bus decode

  // only the word index is decoded; upper address bits alias, so
  // software must keep them clear
  wire [7:0] regIdx   = paddr[9:2];
  wire       accessOn = psel & penable;
  wire       wrStrobe = accessOn & pready & pwrite; // completing write
  wire       rdLoad   = accessOn & ~pready & ~pwrite;
  wire [7:0] wData    = pwdata[7:0];

  wire wrTune  = wrStrobe & (regIdx == `OTS_IDX_TUNE);
  wire wrReq   = wrStrobe & (regIdx == `OTS_IDX_REQ);
  wire wrSwctl = wrStrobe & (regIdx == `OTS_IDX_SWCTL);
  wire wrTrim  = wrStrobe & (regIdx == `OTS_IDX_TRIM);
  wire wrFrq   = wrStrobe & (regIdx == `OTS_IDX_FRQ);
  wire wrEvent = wrStrobe & (regIdx == `OTS_IDX_EVENT);

  // decode of mapped indices, others answer with an error
  reg mapped;
  always @* begin
    case (regIdx)
      `OTS_IDX_TUNE, `OTS_IDX_REQ, `OTS_IDX_CUR, `OTS_IDX_SWCTL,
      `OTS_IDX_TRIM, `OTS_IDX_FRQ, `OTS_IDX_STAT,
      `OTS_IDX_EVENT: mapped = 1'b1;
      default:        mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // crystal edge sync and tuner cycle strobe

  // two flops, only the second is looked at
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      xtalMeta <= 1'b0;
      xtalSync <= 1'b0;
      xtalLast <= 1'b0;
    end else begin
      xtalMeta <= crystalClk;
      xtalSync <= xtalMeta;
      xtalLast <= xtalSync;
    end
  end

  wire xtalRise = xtalSync & ~xtalLast;
  // tuner cycle ends on the last crystal edge of a window
  wire evalNow  = tunerEnable & xtalRise & (periodCount == PER_LAST);

  // window counters; cleared while tuner is off
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      periodCount <= 8'h00;
      fastCount   <= 16'h0000;
    end else if (!tunerEnable) begin
      periodCount <= 8'h00;
      fastCount   <= 16'h0000;
    end else if (evalNow) begin
      periodCount <= 8'h00;
      fastCount   <= 16'h0000;
    end else begin
      if (xtalRise)
        periodCount <= periodCount + 8'h01;
      // saturate so a runaway clock still reads too fast
      if (fastOscTick && fastCount != 16'hffff)
        fastCount <= fastCount + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // tuning decision

  // strict bounds: a count sitting exactly on a limit still locks;
  // the first window after enable is short and may misjudge once
  wire tooFast  = (fastCount > LIM_HI);
  wire tooSlow  = (fastCount < LIM_LO);
  wire atMax    = (trimValue == `OTS_TRIM_MAX);
  wire atMin    = (trimValue == `OTS_TRIM_MIN);
  wire next_lock = ~tooFast & ~tooSlow;
  // trim needed beyond either end of the signed range
  wire next_oor  = (tooFast & atMin) | (tooSlow & atMax);

  // next trim: one step toward nominal, held at the ends
  reg [5:0] next_trim;
  always @* begin
    next_trim = trimValue;
    if (tooFast && !atMin)
      next_trim = trimValue - 6'h01;
    else if (tooSlow && !atMax)
      next_trim = trimValue + 6'h01;
  end

  // only a change of lock or range counts as an event
  wire statusChange = (next_lock != tuneLocked) | (next_oor != tuneOor);
  wire eventSet     = evalNow & statusChange;

  ////////////////////////////////////////////////////////////////////
  // tuning control register

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tunerEnable <= 1'b0;
      tuneHold    <= 1'b0;
    end else if (wrTune) begin
      tunerEnable <= wData[`OTS_B_TEN];
      tuneHold    <= wData[`OTS_B_HOLD];
    end
  end

  // status flags follow the measurement; cleared when off
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tuneLocked <= 1'b0;
      tuneOor    <= 1'b0;
    end else if (!tunerEnable) begin
      tuneLocked <= 1'b0;
      tuneOor    <= 1'b0;
    end else if (evalNow) begin
      tuneLocked <= next_lock;
      tuneOor    <= next_oor;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // trim register

  // hardware steps only with hold clear; software only when off and hold clear
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      trimValue <= `OTS_TRIM_RST;
    end else if (tunerEnable) begin
      if (evalNow && !tuneHold)
        trimValue <= next_trim;
      // software writes dropped while enabled
    end else if (wrTrim && !tuneHold) begin
      trimValue <= wData[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // event flag and interrupt

  // set beats a clear in the same cycle, so an event landing
  // on the clearing write is never lost
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tunerEventFlag <= 1'b0;
      tunerEventIe   <= 1'b0;
      tunerIrq       <= 1'b0;
    end else begin
      if (eventSet)
        tunerEventFlag <= 1'b1;
      else if (wrEvent && wData[`OTS_B_EVFLAG])
        tunerEventFlag <= 1'b0;    // write one to clear
      if (wrEvent)
        tunerEventIe <= wData[`OTS_B_EVIE];
      // irq follows the flag one cycle later
      tunerIrq <= tunerEventFlag & tunerEventIe;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock request and switch

  // a reserved source code throws away the divider of that write
  // too, so a half-applied request can never start a switch
  wire reqReserved = SRC_RESERVED[wData[6:4]];
  wire pending     = (reqSource != activeSource) |
                     (reqDivider != activeDivider);

  // request loaded from straps on the first edge after release
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strapsTaken <= 1'b0;
      reqSource   <= 3'h0;
      reqDivider  <= 4'h0;
    end else if (!strapsTaken) begin
      strapsTaken <= 1'b1;
      reqSource   <= resetClockChoice;
      reqDivider  <= resetDividerChoice;
    end else if (wrReq && switchPermit && !reqReserved) begin
      reqSource   <= wData[6:4];
      reqDivider  <= wData[3:0];
    end
  end

  // ready flag set one cycle after source ready; switch next
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      activeSource  <= 3'h0;
      activeDivider <= 4'h0;
      newSrcReady   <= 1'b0;
    end else if (!strapsTaken) begin
      activeSource  <= resetClockChoice;
      activeDivider <= resetDividerChoice;
      newSrcReady   <= 1'b0;
    end else if (!pending) begin
      newSrcReady   <= 1'b0;
    end else if (newSrcReady && !switchHold) begin
      activeSource  <= reqSource;
      activeDivider <= reqDivider;
      newSrcReady   <= 1'b0;
    end else begin
      newSrcReady   <= sourceReady[reqSource];
    end
  end

  // switch control bits
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      switchHold       <= 1'b0;
      crystalHighPower <= 1'b0;
    end else if (wrSwctl) begin
      switchHold       <= wData[`OTS_B_SWHOLD];
      crystalHighPower <= wData[`OTS_B_XPWR];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // frequency select

  // reserved codes are not stored
  always @(posedge ref_clk or posedge reset) begin
    if (reset)
      freqSelect <= FRQ_RESET;
    else if (wrFrq && wData[3:0] <= `OTS_FRQ_LAST)
      freqSelect <= wData[3:0];
  end

  ////////////////////////////////////////////////////////////////////
  // oscillator ready flags

  // flags are registered, so they lag their inputs by one cycle;
  // bit 0 also needs the multiplier input ready and locked
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : gRdy
      always @(posedge ref_clk or posedge reset) begin
        if (reset)
          oscStatus[gi] <= 1'b0;
        else if (gi == 1)
          oscStatus[gi] <= 1'b0;  // unused bit
        else if (gi == 0)
          oscStatus[gi] <= oscEnabled[gi] & oscReady[gi] &
                           pllInputReady & pllLocked;
        else
          oscStatus[gi] <= oscEnabled[gi] & oscReady[gi];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // read mux

  reg [7:0] next_rd;
  always @* begin
    next_rd = 8'h00;
    case (regIdx)
      `OTS_IDX_TUNE: begin
        next_rd[`OTS_B_TEN]  = tunerEnable;
        next_rd[`OTS_B_HOLD] = tuneHold;
        next_rd[`OTS_B_LOCK] = tuneLocked;
        next_rd[`OTS_B_OOR]  = tuneOor;
      end
      `OTS_IDX_REQ:   next_rd = {1'b0, reqSource, reqDivider};
      `OTS_IDX_CUR:   next_rd = {1'b0, activeSource, activeDivider};
      `OTS_IDX_SWCTL: begin
        next_rd[`OTS_B_SWHOLD] = switchHold;
        next_rd[`OTS_B_XPWR]   = crystalHighPower;
        next_rd[`OTS_B_DONE]   = ~pending;
        next_rd[`OTS_B_NRDY]   = newSrcReady;
      end
      `OTS_IDX_TRIM:  next_rd = {2'b00, trimValue};
      `OTS_IDX_FRQ:   next_rd = {4'h0, freqSelect};
      `OTS_IDX_STAT:  next_rd = oscStatus;
      `OTS_IDX_EVENT: begin
        next_rd[`OTS_B_EVFLAG] = tunerEventFlag;
        next_rd[`OTS_B_EVIE]   = tunerEventIe;
      end
      default:        next_rd = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, data and error registered

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      // one wait state: read data is captured in the first access cycle
      pready <= accessOn & ~pready;
      if (accessOn && !pready)
        pslverr <= ~mapped;
      else
        pslverr <= 1'b0;
      if (rdLoad)
        prdata <= {24'h000000, next_rd};
    end
  end

endmodule
`default_nettype wire

/* File: verification/ots_osc_tune_switch_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ots_map.vh"
module ots_osc_tune_switch_chk #(
  parameter [3:0] FRQ_RESET = 4'h0
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [7:0]  sourceReady,
  input wire logic [5:0]  trimValue,
  input wire logic [3:0]  freqSelect,
  input wire logic [2:0]  activeSource,
  input wire logic        crystalHighPower,
  input wire logic        tunerIrq
);
  // completed writes per target register
  wire logic wrDone = psel & penable & pwrite & pready;
  wire logic trimWr = wrDone & (paddr == {2'b00, `OTS_IDX_TRIM, 2'b00});
  wire logic frqWr  = wrDone & (paddr == {2'b00, `OTS_IDX_FRQ, 2'b00});
  wire logic swWr   = wrDone & (paddr == {2'b00, `OTS_IDX_SWCTL, 2'b00});
  wire logic evWr   = wrDone & (paddr == {2'b00, `OTS_IDX_EVENT, 2'b00});
  logic [1:0] settled; // edges since release, straps load on the first
  logic [7:0] rdyQ;    // ready lines one edge back
  ////////////////////////////////////////////////////////////////////////
  // helper state, cleared with the design
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      settled <= 2'h0;
      rdyQ    <= 8'h00;
    end else begin
      rdyQ <= sourceReady;
      if (settled != 2'h3) begin
        settled <= settled + 2'h1;
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  property p_trimReset;
    settled == 2'h1 |-> trimValue == 6'h00 && freqSelect == FRQ_RESET;
  endproperty
  a_trimReset: assert property (p_trimReset)
    else $error("trim or frequency not at reset value");
  // hardware only ever moves trim by one step
  property p_trimStep;
    settled == 2'h3 && !$stable(trimValue) && !$past(trimWr) |->
      trimValue == $past(trimValue) + 6'h01 ||
      trimValue == $past(trimValue) - 6'h01;
  endproperty
  a_trimStep: assert property (p_trimStep)
    else $error("trim jumped by more than one");
  property p_freqWrite;
    frqWr && pwdata[3:0] <= 4'h8 |=> freqSelect == $past(pwdata[3:0]);
  endproperty
  a_freqWrite: assert property (p_freqWrite)
    else $error("frequency code not taken");
  property p_freqReserved;
    frqWr && pwdata[3:0] > 4'h8 |=> $stable(freqSelect);
  endproperty
  a_freqReserved: assert property (p_freqReserved)
    else $error("reserved frequency code taken");
  property p_freqOnlyByWrite;
    settled == 2'h3 && !$stable(freqSelect) |-> $past(frqWr);
  endproperty
  a_freqOnlyByWrite: assert property (p_freqOnlyByWrite)
    else $error("frequency changed without a write");
  property p_xpwr;
    swWr |=> crystalHighPower == $past(pwdata[6]);
  endproperty
  a_xpwr: assert property (p_xpwr)
    else $error("crystal power mode not written");
  // irq is registered, so it may linger one edge
  property p_irqOff;
    evWr && !pwdata[1] |=> ##1 !tunerIrq;
  endproperty
  a_irqOff: assert property (p_irqOff)
    else $error("irq stays up with enable cleared");
  property p_switchReady;
    settled == 2'h3 && !$stable(activeSource) |-> rdyQ[activeSource];
  endproperty
  a_switchReady: assert property (p_switchReady)
    else $error("switched to a source that was not ready");
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ots_map.vh"
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin nMismatch++; \
  $display("wrong value at %0t: %h not %h", $time, g, e); end end
module tb;
  logic        ref_clk = 1'b0;     // system clock, 40 ns
  logic        reset = 1'b1;       // async, active high
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        crystalClk = 1'b0;  // crystal time base
  logic        switchPermit = 1'b1;
  logic [7:0]  sourceReady = 8'h00;
  logic [7:0]  oscEnabled = 8'h00;
  logic [7:0]  oscReady = 8'h00;
  logic        pllInputReady = 1'b0;
  logic        pllLocked = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, crystalHighPower, tunerIrq;
  logic [5:0]  trimValue, t0;      // t0: saved trim
  logic [3:0]  freqSelect, activeDivider;
  logic [2:0]  activeSource;
  logic [7:0]  rv;                 // last read data
  logic        er;                 // last error response
  int          nMismatch = 0, nChecks = 0, halfPer = 50, xc = 0;
  always #20 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  // crystal half period in cycles; fast ticks come every cycle, so
  // the window count is four half periods: 50 locks, 60 fast, 40 slow
  always @(posedge ref_clk) begin
    if (xc >= halfPer - 1) begin
      xc <= 0;
      crystalClk <= ~crystalClk;
    end else begin
      xc <= xc + 1;
    end
  end
  // short window so the run stays brief
  ots_osc_tune_switch #(.MEAS_PERIODS(2), .EXPECT_COUNT(16'h00c8))
    ots_osc_tune_switch_i (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystalClk(crystalClk),
    .fastOscTick(1'b1), .switchPermit(switchPermit),
    .resetClockChoice(3'h1), .resetDividerChoice(4'h2),
    .sourceReady(sourceReady), .oscEnabled(oscEnabled),
    .oscReady(oscReady), .pllInputReady(pllInputReady),
    .pllLocked(pllLocked), .trimValue(trimValue),
    .freqSelect(freqSelect), .activeSource(activeSource),
    .activeDivider(activeDivider), .crystalHighPower(crystalHighPower),
    .tunerIrq(tunerIrq));
  ////////////////////////////////////////////////////////////////////////
  // one transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [7:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    // no cycle limit here: a hang is ended by the watchdog
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rv = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // the written register shows its new value one edge later
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
    cyc(1);
  endtask
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    `CHK(rv, e)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic testReset;
    rc(`OTS_IDX_TUNE, 8'h00);
    rc(`OTS_IDX_TRIM, 8'h00);
    rc(`OTS_IDX_REQ, 8'h12);
    rc(`OTS_IDX_CUR, 8'h12);
    rc(`OTS_IDX_SWCTL, 8'h10);
    rc(`OTS_IDX_STAT, 8'h00);
    `CHK(freqSelect, 4'h0)
  endtask
  task automatic testTuner;
    wr(`OTS_IDX_TRIM, 8'h20);
    rc(`OTS_IDX_TRIM, 8'h20);
    wr(`OTS_IDX_EVENT, 8'h02);
    halfPer = 60;
    wr(`OTS_IDX_TUNE, 8'h80);
    cyc(1200);
    rc(`OTS_IDX_TUNE, 8'h82);
    `CHK(trimValue, 6'h20)
    rc(`OTS_IDX_EVENT, 8'h03);
    `CHK(tunerIrq, 1'b1)
    wr(`OTS_IDX_TRIM, 8'h05);
    `CHK(trimValue, 6'h20)
    halfPer = 40;
    cyc(800);
    rc(`OTS_IDX_TUNE, 8'h80);
    wr(`OTS_IDX_EVENT, 8'h03);
    t0 = trimValue;
    for (int k = 0; k < 400 && trimValue === t0; k++) cyc(1);
    `CHK(trimValue, t0 + 6'h01)
    rc(`OTS_IDX_EVENT, 8'h02);
    halfPer = 50;
    cyc(1000);
    rc(`OTS_IDX_TUNE, 8'h88);
    wr(`OTS_IDX_TUNE, 8'hc0);
    t0 = trimValue;
    halfPer = 40;
    cyc(800);
    `CHK(trimValue, t0)
    rc(`OTS_IDX_TUNE, 8'hc0);
    wr(`OTS_IDX_EVENT, 8'h01);
    cyc(2);
    `CHK(tunerIrq, 1'b0)
    wr(`OTS_IDX_TUNE, 8'h40);
    wr(`OTS_IDX_TRIM, 8'h11);
    `CHK(trimValue, t0)
    wr(`OTS_IDX_TUNE, 8'h00);
    wr(`OTS_IDX_TRIM, 8'h1f);
    rc(`OTS_IDX_TRIM, 8'h1f);
  endtask
  // switch held while the new source is ready, then released
  task automatic testSwitch;
    wr(`OTS_IDX_REQ, 8'h70);
    rc(`OTS_IDX_REQ, 8'h12);
    wr(`OTS_IDX_SWCTL, 8'hc0);
    `CHK(crystalHighPower, 1'b1)
    wr(`OTS_IDX_REQ, 8'h35);
    rc(`OTS_IDX_SWCTL, 8'hc0);
    sourceReady <= 8'h08;
    cyc(4);
    rc(`OTS_IDX_SWCTL, 8'hc8);
    `CHK(activeSource, 3'h1)
    wr(`OTS_IDX_SWCTL, 8'h00);
    cyc(4);
    `CHK(activeDivider, 4'h5)
    rc(`OTS_IDX_SWCTL, 8'h10);
    rc(`OTS_IDX_CUR, 8'h35);
    switchPermit <= 1'b0;
    wr(`OTS_IDX_REQ, 8'h22);
    rc(`OTS_IDX_REQ, 8'h35);
    // second reset with switching forbidden: request stays at straps
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    cyc(2);
    wr(`OTS_IDX_REQ, 8'h35);
    rc(`OTS_IDX_REQ, 8'h12);
    rc(`OTS_IDX_CUR, 8'h12);
  endtask
  task automatic testFreq;
    for (int i = 0; i < 10; i++) begin
      wr(`OTS_IDX_FRQ, i[7:0]);
      rc(`OTS_IDX_FRQ, (i > 8) ? 8'h08 : i[7:0]);
    end
  endtask
  task automatic testStatus;
    oscEnabled <= 8'hff;
    oscReady <= 8'hfd;
    pllInputReady <= 1'b1;
    cyc(3);
    rc(`OTS_IDX_STAT, 8'hfc);
    pllLocked <= 1'b1;
    cyc(3);
    rc(`OTS_IDX_STAT, 8'hfd);
    apb(1'b0, 8'hb3, 8'h00);
    `CHK(er, 1'b1)
    `CHK(rv, 8'h00)
  endtask
  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(8);
    reset <= 1'b0;
    cyc(2);
    testReset;
    testTuner;
    testSwitch;
    testFreq;
    testStatus;
    tallyAndFinish;
  end
  // watchdog, several times the expected run
  initial begin
    cyc(30000);
    nMismatch++;
    tallyAndFinish;
  end
endmodule
bind ots_osc_tune_switch ots_osc_tune_switch_chk #(.FRQ_RESET(FRQ_RESET))
  ots_osc_tune_switch_chk_i (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .sourceReady(sourceReady), .trimValue(trimValue),
  .freqSelect(freqSelect), .activeSource(activeSource),
  .crystalHighPower(crystalHighPower), .tunerIrq(tunerIrq));
`default_nettype wire
